// [pir_cfg.svh]
// constants of the process image register access block
`ifndef PIR_CFG_SVH
`define PIR_CFG_SVH
// control byte fields
`define PIR_CB_REGCOMM      7
`define PIR_CB_RW           6
`define PIR_CB_AUTOOFF      4
`define PIR_CB_CURRENT      3
`define PIR_CB_AC           2
// status byte fields
`define PIR_SB_ACK          7
`define PIR_SB_ERROR        6
`define PIR_SB_AUTOOFF      4
`define PIR_SB_INVALID      3
`define PIR_SB_EXTENDED     2
`define PIR_SB_OVER         1
`define PIR_SB_UNDER        0
// range codes
`define PIR_RANGE_LOW       2'h0
`define PIR_RANGE_MID       2'h1
`define PIR_RANGE_HIGH      2'h2
`define PIR_RANGE_MILLI     2'h3
// direct register numbers
`define PIR_REG_ADC_RAW     6'h00
`define PIR_REG_RANGE_MODE  6'h01
`define PIR_REG_CALIB       6'h02
`define PIR_REG_SAMPLE_MS   6'h03
`define PIR_REG_PAGE_SEL    6'h04
`define PIR_REG_DIAG        6'h06
`define PIR_REG_COMMAND     6'h07
`define PIR_REG_IDENT       6'h08
`define PIR_REG_FW_REV      6'h09
`define PIR_REG_SHIFT_LEN   6'h0A
`define PIR_REG_CHANNELS    6'h0B
`define PIR_REG_MIN_LEN     6'h0C
`define PIR_REG_DATA_STRUCT 6'h0D
`define PIR_REG_ALIGN       6'h0F
`define PIR_REG_HW_VER      6'h10
`define PIR_REG_TYPE_VER    6'h1D
`define PIR_REG_CODE_WORD   6'h1F
// reset and fixed values
`define PIR_WORD_ZERO       16'h0000
`define PIR_SHIFT_LEN_VAL   16'h0130
`define PIR_TYPE_VER_VAL    16'h0000
`define PIR_CODE_WORD_KEY   16'h1235
`define PIR_CMD_RESTORE     16'h7000
`define PIR_FEATURE_DEFAULT 16'h2804
`define PIR_GAIN_DEFAULT    16'h2000
`define PIR_FIRST_GAIN_IDX  5'h05
`define PIR_LAST_PAGED_IDX  5'h1F
`endif

// [pir_ctl_model.sv]
// controller-side model doing register accesses over the control and status bytes
`timescale 1ns/1ns
module pir_ctl_model (
    input  wire logic        ref_clk,            // system clock
    input  wire logic [7:0]  pm_cb,              // process-mode control byte
    input  wire logic [7:0]  terminal_flag_byte, // status byte seen
    input  wire logic [15:0] input_data_word,    // input word seen
    output logic      [7:0]  host_command_byte,  // control byte sent
    output logic      [15:0] output_data_word    // output word sent
);
    logic       busy = 1'b0;
    logic [7:0] req_cb = 8'h00;
    assign host_command_byte = busy ? req_cb : pm_cb;
    initial output_data_word = 16'h0000;
    // request held until the matching acknowledge, then released for a cycle
    task automatic reg_access(input logic wr, input logic [5:0] r, input logic [15:0] wd,
                              output logic [15:0] rdata, output logic ok);
        ok = 1'b0;
        rdata = 16'h0000;
        @(negedge ref_clk);
        req_cb = {1'b1, wr, r};
        output_data_word = wd;
        busy = 1'b1;
        // status and data are judged where they have settled, off the launching edge
        for (int i = 0; i < 100 && !ok; i++) begin
            @(negedge ref_clk);
            if (terminal_flag_byte === req_cb) begin
                ok = 1'b1;
                rdata = input_data_word;
            end
        end
        busy = 1'b0;
        // released word no longer shows the written value
        output_data_word = ~wd;
    endtask
endmodule

// [pir_mem.sv]
// paged register memory with registered read data
`timescale 1ns/1ns
module pir_mem #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input  wire logic          ref_clk, // system clock
    input  wire logic          we,      // write strobe
    input  wire logic [AW-1:0] waddr,   // write address
    input  wire logic [DW-1:0] wdata,   // write data
    input  wire logic [AW-1:0] raddr,   // read address
    output logic      [DW-1:0] rdata    // read data, one cycle late
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    if (AW < 1 || DW < 1) begin : g_chk
        $error("pir_mem: bad geometry");
    end

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        rdata <= mem[raddr];
    end
endmodule

// [pir_pkg.sv]
// types shared by the process image register access block
package pir_pkg;
    typedef struct packed {
        logic [15:0] adc_raw;     // raw converter result
        logic [15:0] calib;       // internal calibration value
        logic [15:0] sample_ms;   // sampling duration in ms
        logic [15:0] meas_value;  // process value for the input image
        logic        conv_error;  // converter failure
        logic        over_raw;    // above electrical range
        logic        under_raw;   // below electrical range
        logic        ext_zone;    // value in the ~10 % hysteresis zone
        logic        data_valid;  // process value settled
    } pir_meas_t;

    typedef struct packed {
        logic       reg_comm;     // register communication select
        logic       rw;           // 1 = write
        logic [5:0] regno;        // register number
    } pir_cb_t;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_IDLE,
        ST_READ,
        ST_RESP
    } pir_state_t;
endpackage

// [pir_top.sv]
// process image status/control byte handling and direct register file
`timescale 1ns/1ns
`include "pir_cfg.svh"
module pir_top
    import pir_pkg::*;
#(
    parameter logic [15:0] IDENT_VAL    = 16'h0ABC, // arbitrary identifier value
    parameter logic [15:0] FW_REV_VAL   = 16'h3030, // arbitrary revision value
    parameter logic [15:0] CHANNELS_VAL = 16'h0001, // logical channel count
    parameter logic [15:0] MIN_LEN_VAL  = 16'h0000, // minimum data length
    parameter logic [15:0] STRUCT_VAL   = 16'h0000, // data structure
    parameter int          PAGE_AW      = 6         // paged memory address bits
) (
    input  wire logic        ref_clk,           // 100 MHz clock
    input  wire logic        arst_n,            // async reset, active low
    input  wire logic [7:0]  host_command_byte, // control byte from controller
    input  wire logic [15:0] output_data_word,  // output data word from controller
    input  wire pir_meas_t   meas,              // measurement core status
    output logic      [7:0]  terminal_flag_byte, // status byte to controller
    output logic      [15:0] input_data_word,    // input data word to controller
    output logic      [3:0]  range_mode,         // active range/mode bits
    output logic             autorange_off_flag, // autorange disabled
    output logic             restore_busy        // default load in progress
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    pir_cb_t     cb;
    pir_cb_t     last_cb;
    pir_state_t  state;
    logic        acked;
    logic        init_all;
    logic [5:0]  init_addr;
    logic [15:0] page_select;
    logic [15:0] command;
    logic [15:0] alignment;
    logic [15:0] hardware_version;
    logic [15:0] user_code_word;
    logic [7:0]  process_flags;
    logic [15:0] direct_rdata;
    logic [15:0] mem_rdata;
    logic        mem_we;
    logic [5:0]  mem_waddr;
    logic [15:0] mem_wdata;
    logic [5:0]  mem_raddr;
    logic        new_req;
    logic        do_write;
    logic        ext_allowed;
    logic        range_bad;
    logic        under_eff;

    assign cb = pir_cb_t'(host_command_byte);

    if (PAGE_AW != 6) begin : g_chk
        $error("pir_top: paged memory must hold two pages of 32 words");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] page0_default(input logic [4:0] idx);
        if (idx == 5'h00) begin
            return `PIR_FEATURE_DEFAULT;
        end else if (idx >= `PIR_FIRST_GAIN_IDX && idx[0]) begin
            return `PIR_GAIN_DEFAULT;
        end
        return `PIR_WORD_ZERO;
    endfunction

    function automatic logic [5:0] paged_addr(input logic [15:0] sel, input logic [5:0] regno);
        return {sel[0], regno[4:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // process data mode latch of range, mode and autorange
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            range_mode         <= 4'h0;
            autorange_off_flag <= 1'b0;
        end else if (!cb.reg_comm) begin
            range_mode         <= host_command_byte[`PIR_CB_CURRENT:0];
            autorange_off_flag <= host_command_byte[`PIR_CB_AUTOOFF];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // process data status flags
    always_comb begin
        // current has no 300 V range
        range_bad   = range_mode[`PIR_CB_CURRENT] && range_mode[1:0] == `PIR_RANGE_HIGH;
        ext_allowed = range_mode[`PIR_CB_CURRENT] ? (range_mode[1:0] == `PIR_RANGE_MILLI)
                                                  : (range_mode[1:0] != `PIR_RANGE_HIGH);
        under_eff   = meas.under_raw && !range_mode[`PIR_CB_AC];
        process_flags                    = 8'h00;
        process_flags[`PIR_SB_ACK]       = 1'b0;
        process_flags[`PIR_SB_ERROR]     = meas.conv_error | meas.over_raw | under_eff
                                           | range_bad;
        process_flags[`PIR_SB_AUTOOFF]   = autorange_off_flag;
        process_flags[`PIR_SB_INVALID]   = !meas.data_valid;
        process_flags[`PIR_SB_EXTENDED]  = meas.ext_zone && ext_allowed;
        process_flags[`PIR_SB_OVER]      = meas.over_raw;
        process_flags[`PIR_SB_UNDER]     = under_eff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // direct register read decode
    always_comb begin
        direct_rdata = `PIR_WORD_ZERO;
        if (cb.regno == `PIR_REG_ADC_RAW) begin
            direct_rdata = meas.adc_raw;
        end else if (cb.regno == `PIR_REG_RANGE_MODE) begin
            direct_rdata = {12'h000, range_mode};
        end else if (cb.regno == `PIR_REG_CALIB) begin
            direct_rdata = meas.calib;
        end else if (cb.regno == `PIR_REG_SAMPLE_MS) begin
            direct_rdata = meas.sample_ms;
        end else if (cb.regno == `PIR_REG_PAGE_SEL) begin
            direct_rdata = page_select;
        end else if (cb.regno == `PIR_REG_DIAG) begin
            direct_rdata = {8'h00, process_flags};
        end else if (cb.regno == `PIR_REG_COMMAND) begin
            direct_rdata = command;
        end else if (cb.regno == `PIR_REG_IDENT) begin
            direct_rdata = IDENT_VAL;
        end else if (cb.regno == `PIR_REG_FW_REV) begin
            direct_rdata = FW_REV_VAL;
        end else if (cb.regno == `PIR_REG_SHIFT_LEN) begin
            direct_rdata = `PIR_SHIFT_LEN_VAL;
        end else if (cb.regno == `PIR_REG_CHANNELS) begin
            direct_rdata = CHANNELS_VAL;
        end else if (cb.regno == `PIR_REG_MIN_LEN) begin
            direct_rdata = MIN_LEN_VAL;
        end else if (cb.regno == `PIR_REG_DATA_STRUCT) begin
            direct_rdata = STRUCT_VAL;
        end else if (cb.regno == `PIR_REG_ALIGN) begin
            direct_rdata = alignment;
        end else if (cb.regno == `PIR_REG_HW_VER) begin
            direct_rdata = hardware_version;
        end else if (cb.regno == `PIR_REG_TYPE_VER) begin
            direct_rdata = `PIR_TYPE_VER_VAL;
        end else if (cb.regno == `PIR_REG_CODE_WORD) begin
            direct_rdata = user_code_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request detection and access sequencing
    assign new_req  = cb.reg_comm && (!acked || cb != last_cb);
    assign do_write = state == ST_IDLE && new_req && cb.rw;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_INIT;
            acked   <= 1'b0;
            last_cb <= pir_cb_t'(8'h00);
        end else begin
            case (state)
                ST_INIT: begin
                    if (init_addr[4:0] == `PIR_LAST_PAGED_IDX && (!init_all || init_addr[5])) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!cb.reg_comm) begin
                        acked <= 1'b0;
                    end else if (new_req) begin
                        last_cb <= cb;
                        acked   <= 1'b0;
                        state   <= cb.rw ? ST_RESP : ST_READ;
                    end
                end
                ST_READ: begin
                    state <= ST_RESP;
                end
                ST_RESP: begin
                    acked <= 1'b1;
                    if (cb.rw && cb.regno == `PIR_REG_COMMAND && command == `PIR_CMD_RESTORE
                        && user_code_word == `PIR_CODE_WORD_KEY) begin
                        state <= ST_INIT;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // default loader: both pages after reset, page 0 on restore command
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_addr <= 6'h00;
            init_all  <= 1'b1;
        end else if (state == ST_INIT) begin
            init_addr <= init_addr + 6'h01;
        end else begin
            init_addr <= 6'h00;
            init_all  <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            restore_busy <= 1'b1;
        end else begin
            restore_busy <= state == ST_INIT
                            && !(init_addr[4:0] == `PIR_LAST_PAGED_IDX && (!init_all || init_addr[5]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // writable direct registers; read-only ones ignore writes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_select      <= `PIR_WORD_ZERO;
            alignment        <= `PIR_WORD_ZERO;
            hardware_version <= `PIR_WORD_ZERO;
            user_code_word   <= `PIR_WORD_ZERO;
        end else if (do_write) begin
            if (cb.regno == `PIR_REG_PAGE_SEL) begin
                page_select <= output_data_word;
            end else if (cb.regno == `PIR_REG_ALIGN) begin
                alignment <= output_data_word;
            end else if (cb.regno == `PIR_REG_HW_VER) begin
                hardware_version <= output_data_word;
            end else if (cb.regno == `PIR_REG_CODE_WORD) begin
                user_code_word <= output_data_word;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            command <= `PIR_WORD_ZERO;
        end else if (do_write && cb.regno == `PIR_REG_COMMAND
                     && user_code_word == `PIR_CODE_WORD_KEY) begin
            command <= output_data_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // paged memory at numbers 32..63
    always_comb begin
        if (state == ST_INIT) begin
            mem_we    = 1'b1;
            mem_waddr = init_addr;
            mem_wdata = init_addr[5] ? `PIR_WORD_ZERO : page0_default(init_addr[4:0]);
        end else begin
            // page 1 holds calibration data and is never written from the bus
            mem_we    = do_write && cb.regno[5] && !page_select[0];
            mem_waddr = paged_addr(page_select, cb.regno);
            mem_wdata = output_data_word;
        end
    end

    assign mem_raddr = paged_addr(page_select, cb.regno);

    pir_mem #(
        .AW (PAGE_AW),
        .DW (16)
    ) pir_mem_inst (
        .ref_clk (ref_clk),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata   (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // process image outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            terminal_flag_byte <= 8'h00;
            input_data_word    <= `PIR_WORD_ZERO;
        end else if (!cb.reg_comm) begin
            terminal_flag_byte <= process_flags;
            input_data_word    <= meas.meas_value;
        end else if (state == ST_RESP) begin
            terminal_flag_byte <= {1'b1, last_cb.rw, last_cb.regno};
            if (!last_cb.rw) begin
                input_data_word <= last_cb.regno[5] ? mem_rdata : direct_rdata;
            end
        end else if (state != ST_IDLE || new_req) begin
            terminal_flag_byte[`PIR_SB_ACK] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb_chk @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_proc_ack_low: assert property (!cb.reg_comm |=> !terminal_flag_byte[`PIR_SB_ACK])
        else $error("ack set in process data mode");
    a_proc_over: assert property (!cb.reg_comm ##1 !cb.reg_comm
        |-> terminal_flag_byte[`PIR_SB_OVER] == $past(meas.over_raw))
        else $error("overrange flag wrong");
    a_under_ac: assert property ($past(!cb.reg_comm) && $past(range_mode[`PIR_CB_AC])
        |-> !terminal_flag_byte[`PIR_SB_UNDER])
        else $error("underrange shown in AC mode");
    a_error_covers: assert property (!cb.reg_comm && (meas.over_raw || meas.conv_error)
        |=> terminal_flag_byte[`PIR_SB_ERROR])
        else $error("error flag missing");
    a_ext_ranges: assert property (!cb.reg_comm && range_mode == {1'b0, 1'b0, `PIR_RANGE_HIGH}
        |=> !terminal_flag_byte[`PIR_SB_EXTENDED])
        else $error("extended range shown for 300 V");
    a_ack_echo: assert property (state == ST_RESP && cb.reg_comm
        |=> terminal_flag_byte == {1'b1, $past(last_cb.rw), $past(last_cb.regno)})
        else $error("acknowledge does not echo request");
    a_ack_bound: assert property (state == ST_IDLE && new_req |-> ##[1:2] state == ST_RESP
        || !cb.reg_comm)
        else $error("request not answered in time");
    a_shift_len: assert property (state == ST_RESP && !last_cb.rw && cb.reg_comm
        && last_cb.regno == `PIR_REG_SHIFT_LEN |=> input_data_word == `PIR_SHIFT_LEN_VAL)
        else $error("shift length register wrong");
    a_cmd_locked: assert property (user_code_word != `PIR_CODE_WORD_KEY |=> $stable(command))
        else $error("command accepted without key");
    a_ro_page1: assert property (state != ST_INIT && page_select[0] |-> !mem_we)
        else $error("calibration page written");
endmodule

// [tb_process_image_register_access.sv]
// self-checking bench for the process image register access block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_process_image_register_access
    import pir_pkg::*;
();
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  pm_cb = 8'h00;
    pir_meas_t   meas = '0;
    logic [7:0]  host_command_byte, terminal_flag_byte;
    logic [15:0] output_data_word, input_data_word;
    logic [3:0]  range_mode;
    logic        autorange_off_flag, restore_busy;
    int          error_cnt = 0;
    int          n_tests = 0;
    pir_top pir_top_inst (.ref_clk, .arst_n, .host_command_byte, .output_data_word, .meas,
        .terminal_flag_byte, .input_data_word, .range_mode, .autorange_off_flag, .restore_busy);
    pir_ctl_model pir_ctl_model_inst (.ref_clk, .pm_cb, .terminal_flag_byte, .input_data_word,
        .host_command_byte, .output_data_word);
    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic rd(input logic [5:0] r, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        pir_ctl_model_inst.reg_access(1'b0, r, 16'h0000, d, ok);
        `CHK("read ack", 1'b1, ok)
        `CHK($sformatf("reg %0d", r), e, d)
    endtask
    task automatic wr(input logic [5:0] r, input logic [15:0] v);
        logic [15:0] d;
        logic        ok;
        pir_ctl_model_inst.reg_access(1'b1, r, v, d, ok);
        `CHK("write ack", 1'b1, ok)
    endtask
    task automatic idle_wait();
        for (int i = 0; i < 200 && restore_busy !== 1'b0; i++) @(negedge ref_clk);
        `CHK("loader done", 1'b0, restore_busy)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [5:0] rn[8] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h1D, 6'h1F};
        foreach (rn[i]) rd(rn[i], 16'h0000);
        rd(6'h0A, 16'h0130);
        meas.adc_raw = 16'h1234;
        meas.sample_ms = 16'h0032;
        rd(6'h00, 16'h1234);
        rd(6'h03, 16'h0032);
        $display("t_regs done");
    endtask
    task automatic t_rw();
        wr(6'h04, 16'h0001);
        rd(6'h04, 16'h0001);
        rd(6'h20, 16'h0000);
        wr(6'h00, 16'hFFFF);
        rd(6'h00, 16'h1234);
        wr(6'h0A, 16'h0000);
        rd(6'h0A, 16'h0130);
        wr(6'h05, 16'hFFFF);
        rd(6'h05, 16'h0000);
        wr(6'h04, 16'h0000);
        rd(6'h20, 16'h2804);
        $display("t_rw done");
    endtask
    task automatic t_cmd();
        wr(6'h25, 16'h1111);
        rd(6'h25, 16'h1111);
        wr(6'h07, 16'h7000);
        @(negedge ref_clk);
        `CHK("no restore", 1'b0, restore_busy)
        rd(6'h07, 16'h0000);
        wr(6'h04, 16'h0001);
        wr(6'h21, 16'hFFFF);
        rd(6'h21, 16'h0000);
        wr(6'h1F, 16'h1235);
        rd(6'h1F, 16'h1235);
        wr(6'h07, 16'h7000);
        @(negedge ref_clk);
        `CHK("restore", 1'b1, restore_busy)
        idle_wait();
        wr(6'h04, 16'h0000);
        rd(6'h25, 16'h2000);
        $display("t_cmd done");
    endtask
    task automatic t_reset();
        wr(6'h04, 16'h0001);
        @(negedge ref_clk);
        arst_n = 1'b0;
        @(negedge ref_clk);
        `CHK("reset flags", 8'h00, terminal_flag_byte)
        `CHK("reset busy", 1'b1, restore_busy)
        arst_n = 1'b1;
        idle_wait();
        rd(6'h04, 16'h0000);
        rd(6'h1F, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_flags();
        // control byte, {error, over, under, ext, valid}, mask, expected
        logic [31:0] tab[12] = '{32'h0001FF00, 32'h0009FF42, 32'h0005FF41, 32'h04050100,
            32'h0000FF08, 32'h1001FF10, 32'h03030404, 32'h02030400, 32'h0B030404,
            32'h08030400, 32'h00114040, 32'h0A014040};
        foreach (tab[i]) begin
            pm_cb = tab[i][31:24];
            {meas.conv_error, meas.over_raw, meas.under_raw, meas.ext_zone, meas.data_valid} = tab[i][20:16];
            repeat (2) @(negedge ref_clk);
            `CHK($sformatf("flags %0d", i), tab[i][7:0], terminal_flag_byte & tab[i][15:8])
            `CHK("range latch", tab[i][28:24], {autorange_off_flag, range_mode})
        end
        pm_cb = 8'h00;
        meas.meas_value = 16'h5A5A;
        {meas.conv_error, meas.over_raw, meas.under_raw, meas.ext_zone, meas.data_valid} = 5'h09;
        repeat (2) @(negedge ref_clk);
        `CHK("process word", 16'h5A5A, input_data_word)
        rd(6'h06, 16'h0042);
        $display("t_flags done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        meas.data_valid = 1'b1;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        idle_wait();
        t_regs();
        t_rw();
        t_cmd();
        t_reset();
        t_flags();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("[ERR] watchdog expired");
        tally_and_finish();
    end
endmodule
